/* design/scp_pkg.sv */
// Package: role, rate and timing constants for the stack comm port block
package scp_pkg;
   // Device role in the stack
   typedef enum logic [1:0] {
      SCP_ROLE_ALONE  = 2'h0,
      SCP_ROLE_BOTTOM = 2'h1,
      SCP_ROLE_TOP    = 2'h2,
      SCP_ROLE_MIDDLE = 2'h3
   } scp_role_e;

   // Chain bit rates in kHz, per rate code
   localparam int RATE_KHZ_00 = 62;
   localparam int RATE_KHZ_01 = 125;
   localparam int RATE_KHZ_10 = 250;
   localparam int RATE_KHZ_11 = 500;
   localparam int CLK_KHZ     = 100000;
   // Half bit period in clk cycles (Manchester needs two halves per bit)
   localparam int HALF_00 = CLK_KHZ / (2 * RATE_KHZ_00);
   localparam int HALF_01 = CLK_KHZ / (2 * RATE_KHZ_01);
   localparam int HALF_10 = CLK_KHZ / (2 * RATE_KHZ_10);
   localparam int HALF_11 = CLK_KHZ / (2 * RATE_KHZ_11);
   localparam int CNT_W   = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;

   // Chain length limit on middle members
   localparam int MAX_MIDDLE = 12;

   // Bridge buffer defaults
   localparam int BUF_DEPTH = 16;
   localparam int BUF_AW    = 4;
   localparam logic [BUF_AW:0] PTR_ONE = 5'h01;

   // Half bit period for a rate code
   function automatic logic [CNT_W-1:0] half_cycles(input logic [1:0] code);
      case (code)
         2'h0:    half_cycles = CNT_W'(HALF_00);
         2'h1:    half_cycles = CNT_W'(HALF_01);
         2'h2:    half_cycles = CNT_W'(HALF_10);
         default: half_cycles = CNT_W'(HALF_11);
      endcase
   endfunction
endpackage

/* design/scp_buf_if.sv */
// Interface: write and read sides of the bridge byte buffer
`timescale 1ns/1ps
interface scp_buf_if;
   logic       wr_valid;  // Byte offered
   logic       wr_ready;  // Space free
   logic [7:0] wr_data;   // Byte in
   logic       rd_valid;  // Byte held
   logic       rd_ready;  // Consumer takes
   logic [7:0] rd_data;   // Byte out
   modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

/* design/scp_buf.sv */
// Module: small byte memory that buffers traffic between host and chain
`timescale 1ns/1ps
module scp_buf #(
   parameter int AW = scp_pkg::BUF_AW
) (
   input wire logic clk,
   input wire logic nrst,
   scp_buf_if.fifo  bus
);
   logic [7:0]  mem_ff [2**AW];  // Storage
   logic [AW:0] wp_ff;           // Write pointer with wrap bit
   logic [AW:0] rp_ff;           // Read pointer with wrap bit
   logic [7:0]  dout_ff;         // Registered read data
   logic        dval_ff;         // Read data valid
   wire         full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   wire         empty = (wp_ff == rp_ff);
   wire         push  = bus.wr_valid && !full;
   wire         load  = !empty && (!dval_ff || bus.rd_ready);

   assign bus.wr_ready = !full;
   assign bus.rd_valid = dval_ff;
   assign bus.rd_data  = dout_ff;

   // Storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wp_ff[AW-1:0]] <= bus.wr_data;
      end
   end

   // Pointers and output register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wp_ff   <= '0;
         rp_ff   <= '0;
         dval_ff <= 1'b0;
         dout_ff <= 8'h00;
      end else begin
         if (push) wp_ff <= wp_ff + (AW+1)'(scp_pkg::PTR_ONE);
         if (load) begin
            dout_ff <= mem_ff[rp_ff[AW-1:0]];
            rp_ff   <= rp_ff + (AW+1)'(scp_pkg::PTR_ONE);
            dval_ff <= 1'b1;
         end else if (bus.rd_ready) begin
            dval_ff <= 1'b0;
         end
      end
   end
endmodule

/* design/scp_top.sv */
// Module: stack comm port role select, link routing, chain rate and bridge
`timescale 1ns/1ps
module scp_top (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       link_role_pin_a,
   input  wire logic       link_role_pin_b,
   input  wire logic       chain_speed_pin_a,
   input  wire logic       chain_speed_pin_b,
   input  wire logic       addressed,
   input  wire logic       spi_sck,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_mosi,
   output logic            spi_miso_o,
   output logic            spi_miso_oe,
   input  wire logic       p1_rx,
   output logic            p1_tx_o,
   output logic            p1_tx_oe,
   input  wire logic       p2_rx,
   output logic            p2_tx_o,
   output logic            p2_tx_oe,
   output logic [1:0]      role_o,
   output logic            p2_enable_o,
   output logic            spi_full_duplex_o,
   output logic            buf_overflow_o
);
   // Synchronisers for pins (first stage read only by second)
   logic [1:0] cfg_s1_ff, cfg_s2_ff;    // Role pins
   logic [1:0] spd_s1_ff, spd_s2_ff;    // Speed pins
   logic [2:0] spi_s1_ff, spi_s2_ff;    // sck, cs_n, mosi
   logic       p1_s1_ff, p1_s2_ff;      // Port 1 line
   logic       p2_s1_ff, p2_s2_ff;      // Port 2 line
   logic       adr_s1_ff, adr_s2_ff;    // Addressed flag
   logic       sck_d_ff;                // Previous sck
   logic       cfg_done_ff;             // Config latched
   logic [1:0] role_ff;                 // Latched role
   logic [1:0] spd_ff;                  // Latched speed
   logic [7:0] sh_in_ff;                // SPI receive shift
   logic [2:0] bit_ff;                  // SPI bit count
   logic [7:0] sh_out_ff;               // SPI send shift
   logic [scp_pkg::CNT_W-1:0] tick_ff;  // Half bit counter
   logic       half_ff;                 // Second half of bit
   logic [7:0] tx_byte_ff;              // Chain send shift
   logic [3:0] tx_cnt_ff;               // Bits left
   logic       tx_line_ff;              // Encoded line level
   logic       p1_o_ff, p1_oe_ff, p2_o_ff, p2_oe_ff;
   logic       miso_ff, miso_oe_ff, ovf_ff;
   logic       p2en_ff, fdx_ff;         // Registered port mode flags

   typedef enum logic [2:0] {
      SCP_ST_IDLE = 3'b001,
      SCP_ST_LOAD = 3'b010,
      SCP_ST_SEND = 3'b100
   } scp_state_e;
   scp_state_e st_ff, nxt_st;

   scp_buf_if bi ();
   scp_buf #(.AW(scp_pkg::BUF_AW)) u_buf (.clk(clk), .nrst(nrst), .bus(bi));

   // Role decode from latched pins; one role per device, chain makeup is the system's
   wire is_alone  = role_ff == scp_pkg::SCP_ROLE_ALONE;
   wire is_bottom = role_ff == scp_pkg::SCP_ROLE_BOTTOM;
   wire is_top    = role_ff == scp_pkg::SCP_ROLE_TOP;
   wire is_middle = role_ff == scp_pkg::SCP_ROLE_MIDDLE;
   wire spi_used  = is_alone || is_bottom;
   wire p2_used   = is_bottom || is_middle;
   // Only masters steer; a middle not addressed repeats
   wire repeater  = is_middle && !adr_s2_ff;
   wire sck_rise  = spi_s2_ff[0] && !sck_d_ff && !spi_s2_ff[1];
   wire byte_done = sck_rise && (bit_ff == 3'h7);
   wire [7:0] rx_byte = {sh_in_ff[6:0], spi_s2_ff[2]};
   wire [scp_pkg::CNT_W-1:0] half_len = scp_pkg::half_cycles(spd_ff);
   wire tick_end  = tick_ff == half_len - scp_pkg::CNT_ONE;
   wire [7:0] spi_echo = bi.rd_valid ? bi.rd_data : 8'h00;

   // Input synchronisers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_s1_ff <= 2'h0; cfg_s2_ff <= 2'h0;
         spd_s1_ff <= 2'h0; spd_s2_ff <= 2'h0;
         spi_s1_ff <= 3'h2; spi_s2_ff <= 3'h2;
         p1_s1_ff  <= 1'b0; p1_s2_ff  <= 1'b0;
         p2_s1_ff  <= 1'b0; p2_s2_ff  <= 1'b0;
         adr_s1_ff <= 1'b0; adr_s2_ff <= 1'b0;
         sck_d_ff  <= 1'b0;
      end else begin
         cfg_s1_ff <= {link_role_pin_a, link_role_pin_b};
         cfg_s2_ff <= cfg_s1_ff;
         spd_s1_ff <= {chain_speed_pin_a, chain_speed_pin_b};
         spd_s2_ff <= spd_s1_ff;
         spi_s1_ff <= {spi_mosi, spi_cs_n, spi_sck};
         spi_s2_ff <= spi_s1_ff;
         p1_s1_ff  <= p1_rx;  p1_s2_ff <= p1_s1_ff;
         p2_s1_ff  <= p2_rx;  p2_s2_ff <= p2_s1_ff;
         adr_s1_ff <= addressed; adr_s2_ff <= adr_s1_ff;
         sck_d_ff  <= spi_s2_ff[0];
      end
   end

   // Latch config once, three edges after release, then hold
   logic [1:0] wait_ff;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wait_ff <= 2'h0; cfg_done_ff <= 1'b0;
         role_ff <= 2'h0; spd_ff <= 2'h0;
      end else if (!cfg_done_ff) begin
         wait_ff <= wait_ff + 2'h1;
         if (wait_ff == 2'h2) begin
            cfg_done_ff <= 1'b1;
            role_ff <= cfg_s2_ff;
            spd_ff  <= spd_s2_ff;
         end
      end
   end

   // SPI slave shift, bytes pushed into the bridge buffer at bottom only
   always_ff @(posedge clk) begin
      if (!nrst || spi_s2_ff[1]) begin
         bit_ff <= 3'h0; sh_in_ff <= 8'h00; sh_out_ff <= 8'h00;
      end else if (sck_rise && spi_used) begin
         bit_ff    <= bit_ff + 3'h1;
         sh_in_ff  <= rx_byte;
         sh_out_ff <= (bit_ff == 3'h7) ? spi_echo : {sh_out_ff[6:0], 1'b0};
      end
   end
   assign bi.wr_valid = byte_done && is_bottom;
   assign bi.wr_data  = rx_byte;

   // Chain sender state
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         SCP_ST_IDLE: if (bi.rd_valid && is_bottom) nxt_st = SCP_ST_LOAD;
         SCP_ST_LOAD: nxt_st = SCP_ST_SEND;
         SCP_ST_SEND: if (tx_cnt_ff == 4'h0 && half_ff && tick_end) nxt_st = SCP_ST_IDLE;
         default:     nxt_st = SCP_ST_IDLE;
      endcase
   end
   assign bi.rd_ready = st_ff == SCP_ST_LOAD;

   // Manchester send: DC balanced, each bit both levels
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_ff <= SCP_ST_IDLE; tick_ff <= scp_pkg::CNT_ZERO; half_ff <= 1'b0;
         tx_byte_ff <= 8'h00; tx_cnt_ff <= 4'h0; tx_line_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         if (st_ff == SCP_ST_LOAD) begin
            tx_byte_ff <= bi.rd_data; tx_cnt_ff <= 4'h7;
            tick_ff <= scp_pkg::CNT_ZERO; half_ff <= 1'b0;
            tx_line_ff <= bi.rd_data[7];
         end else if (st_ff == SCP_ST_SEND) begin
            tick_ff <= tick_end ? scp_pkg::CNT_ZERO : tick_ff + scp_pkg::CNT_ONE;
            if (tick_end) begin
               half_ff <= !half_ff;
               if (!half_ff) begin
                  tx_line_ff <= !tx_line_ff;
               end else if (tx_cnt_ff != 4'h0) begin
                  tx_cnt_ff  <= tx_cnt_ff - 4'h1;
                  tx_byte_ff <= {tx_byte_ff[6:0], 1'b0};
                  tx_line_ff <= tx_byte_ff[6];
               end
            end
         end
      end
   end

   // Port drive per role; repeaters pass data up and down
   always_ff @(posedge clk) begin
      if (!nrst) begin
         p1_o_ff <= 1'b0; p1_oe_ff <= 1'b0; p2_o_ff <= 1'b0; p2_oe_ff <= 1'b0;
         miso_ff <= 1'b0; miso_oe_ff <= 1'b0; ovf_ff <= 1'b0;
         p2en_ff <= 1'b0; fdx_ff <= 1'b0;
      end else begin
         // Mode flags from flops so the pins see no decode glitches
         p2en_ff  <= cfg_done_ff && p2_used;
         fdx_ff   <= cfg_done_ff && is_alone;
         p1_o_ff  <= is_middle ? p2_s2_ff : (is_top ? 1'b0 : 1'b0);
         p1_oe_ff <= cfg_done_ff && repeater && !p1_s2_ff;
         p2_o_ff  <= is_bottom ? tx_line_ff : p1_s2_ff;
         p2_oe_ff <= cfg_done_ff && ((is_bottom && st_ff == SCP_ST_SEND) ||
                                     (repeater && !p2_s2_ff));
         miso_ff  <= sh_out_ff[7];
         // Full duplex drives always selected; half duplex only after a byte
         miso_oe_ff <= cfg_done_ff && !spi_s2_ff[1] &&
                       (is_alone || (is_bottom && bi.rd_valid));
         if (bi.wr_valid && !bi.wr_ready) ovf_ff <= 1'b1;
      end
   end

   assign p1_tx_o           = p1_o_ff;
   assign p1_tx_oe          = p1_oe_ff;
   assign p2_tx_o           = p2_o_ff;
   assign p2_tx_oe          = p2_oe_ff;
   assign spi_miso_o        = miso_ff;
   assign spi_miso_oe       = miso_oe_ff;
   assign role_o            = role_ff;
   assign p2_enable_o       = p2en_ff;
   assign spi_full_duplex_o = fdx_ff;
   assign buf_overflow_o    = ovf_ff;

   // Config holds steady once latched
   a_cfg_stable: assert property (@(posedge clk) disable iff (!nrst)
      $past(cfg_done_ff) |-> $stable(role_ff) && $stable(spd_ff))
      else $error("config changed after latch");
   // Top never enables port 2
   a_top_no_p2: assert property (@(posedge clk) disable iff (!nrst)
      is_top |-> !p2_oe_ff) else $error("top drove port 2");
   // Stand-alone never drives chain ports
   a_alone_quiet: assert property (@(posedge clk) disable iff (!nrst)
      is_alone |-> !p1_oe_ff && !p2_oe_ff) else $error("alone drove chain");
   // Bottom never drives port 1 as chain
   a_bottom_p1: assert property (@(posedge clk) disable iff (!nrst)
      is_bottom |-> !p1_oe_ff) else $error("bottom drove port 1");
   // Half length is 100 cycles for speed code 3
   a_rate_map: assert property (@(posedge clk) disable iff (!nrst)
      cfg_done_ff && spd_ff == 2'h3 |-> half_len == 10'h064)
      else $error("rate map wrong");
   // A received byte at bottom lands in buffer
   a_buf_push: assert property (@(posedge clk) disable iff (!nrst)
      byte_done && is_bottom && bi.wr_ready |=> !$stable(u_buf.wp_ff))
      else $error("byte lost");
   // Load then send sequence
   sequence s_load; st_ff == SCP_ST_LOAD; endsequence
   a_load_send: assert property (@(posedge clk) disable iff (!nrst)
      s_load |=> st_ff == SCP_ST_SEND) else $error("send not started");
   // Middle repeats port 1 onto port 2
   a_repeat: assert property (@(posedge clk) disable iff (!nrst)
      repeater && $stable(p1_s2_ff) |=> p2_o_ff == $past(p1_s2_ff))
      else $error("repeat broken");
endmodule

/* sim/scp_chain_peer.sv */
// Chain neighbour model: rests its own line and measures the port's drive
`timescale 1ns/1ps
module scp_chain_peer (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic tx_o,
   input  wire logic tx_oe,
   output logic      rx,
   output logic      seen,
   output int        min_gap,
   output int        hi_cnt,
   output int        lo_cnt
);
   int   gap;       // Clocks since the last line edge
   logic had_edge;  // A first edge seen in this burst
   logic last_tx;   // Line level one clock ago

   // AC-coupled pair at rest; the neighbour offers no traffic of its own
   assign rx = 1'b0;

   // Edge spacing and level balance while the port drives
   always @(posedge clk) begin
      last_tx <= tx_o;
      if (!nrst) begin
         seen     <= 1'b0;
         min_gap  <= 100000;
         hi_cnt   <= 0;
         lo_cnt   <= 0;
         gap      <= 0;
         had_edge <= 1'b0;
      end else if (tx_oe) begin
         seen <= 1'b1;
         gap  <= gap + 1;
         // Count levels, equal halves mean no DC content
         if (tx_o) begin
            hi_cnt <= hi_cnt + 1;
         end else begin
            lo_cnt <= lo_cnt + 1;
         end
         // Shortest gap between edges is one half bit
         if (tx_o !== last_tx) begin
            if (had_edge && gap < min_gap) begin
               min_gap <= gap;
            end
            had_edge <= 1'b1;
            gap      <= 1;
         end
      end else begin
         gap      <= 0;
         had_edge <= 1'b0;
      end
   end
endmodule

/* sim/stack_comm_port_config_bench.sv */
// Testbench: role table, chain rate, bridge overflow and pin latching
`timescale 1ns/1ps
module stack_comm_port_config_bench;
   logic clk = 1'b0;            // System clock
   logic nrst = 1'b0;           // Sync reset, active low
   logic role_a = 1'b0;         // First role pin
   logic role_b = 1'b0;         // Second role pin
   logic spd_a = 1'b1;          // First speed pin
   logic spd_b = 1'b1;          // Second speed pin
   logic spi_sck = 1'b0;        // Host serial clock, still outside frames
   logic spi_cs_n = 1'b1;       // Host select, active low
   logic spi_mosi = 1'b0;       // Host data out
   logic adr = 1'b0;            // Addressed flag for a middle device
   logic miso_o, miso_oe, p1_rx, p1_tx_o, p1_tx_oe, p2_rx, p2_tx_o, p2_tx_oe;
   logic [1:0] role_o;          // Latched role
   logic p2_en, full_dx, ovf;   // Port mode flags, buffer overflow
   logic s1, s2;                // Ports seen driving
   int   g1, g2, h1, h2, l1, l2; // Peer measurements
   int   fail_count = 0;        // Mismatches
   int   cmp_count = 0;         // Comparisons
   int   cyc = 0;               // Cycle count for the hang guard
   int   rates [4] = '{62, 125, 250, 500}; // Chain rates in kHz per code
   int   r, c, i, d;            // Loop indices

   // 100 MHz clock
   always #5 clk = ~clk;

   scp_top u_dut (.clk(clk), .nrst(nrst), .link_role_pin_a(role_a),
      .link_role_pin_b(role_b), .chain_speed_pin_a(spd_a), .chain_speed_pin_b(spd_b),
      .addressed(adr), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .p1_rx(p1_rx), .p1_tx_o(p1_tx_o),
      .p1_tx_oe(p1_tx_oe), .p2_rx(p2_rx), .p2_tx_o(p2_tx_o), .p2_tx_oe(p2_tx_oe),
      .role_o(role_o), .p2_enable_o(p2_en), .spi_full_duplex_o(full_dx),
      .buf_overflow_o(ovf));
   scp_chain_peer u_peer1 (.clk(clk), .nrst(nrst), .tx_o(p1_tx_o), .tx_oe(p1_tx_oe),
      .rx(p1_rx), .seen(s1), .min_gap(g1), .hi_cnt(h1), .lo_cnt(l1));
   scp_chain_peer u_peer2 (.clk(clk), .nrst(nrst), .tx_o(p2_tx_o), .tx_oe(p2_tx_oe),
      .rx(p2_rx), .seen(s2), .min_gap(g2), .hi_cnt(h2), .lo_cnt(l2));

   // Compare and report one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Verdict and stop
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Reset with pins set first, since they are latched after release
   task automatic do_reset(input logic a, input logic b, input logic [1:0] spd);
      @(posedge clk);
      nrst   <= 1'b0;
      role_a <= a;
      role_b <= b;
      spd_a  <= spd[1];
      spd_b  <= spd[0];
      repeat (12) @(posedge clk);
      chk(role_o, 2'h0);
      nrst <= 1'b1;
      repeat (10) @(posedge clk);
   endtask

   // One host byte, MSB first; link clock off the system clock phase
   task automatic spi_byte(input logic [7:0] b);
      #3 spi_cs_n = 1'b0;
      for (int k = 7; k >= 0; k--) begin
         spi_mosi = b[k];
         #62.5 spi_sck = 1'b1;
         #62.5 spi_sck = 1'b0;
      end
      #62.5 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      // Keep select high long enough for the synchroniser to see the frame end
      #62.5;
   endtask

   // Bounded wait for the chain drive enable to reach a level
   task automatic wait_oe(input logic lvl, input int lim);
      d = 0;
      while (p2_tx_oe !== lvl && d < lim) begin
         @(posedge clk);
         d++;
      end
      chk(p2_tx_oe, lvl);
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         fail_count++;
         end_sim();
      end
   end

   initial begin
      // Every role code: port modes, bottom forwards, pins latched
      for (r = 0; r < 4; r++) begin
         do_reset(r[1], r[0], 2'h3);
         chk(role_o, r[1:0]);
         chk(p2_en, r[0]);
         chk(full_dx, r == 0);
         spi_byte(8'hA5);
         repeat (300) @(posedge clk);
         chk(s2, r[0]);
         chk(s1, r == 3);
         if (r == 3) begin
            // An addressed middle stops repeating on both ports
            adr <= 1'b1;
            repeat (6) @(posedge clk);
            chk(p1_tx_oe, 1'b0);
            chk(p2_tx_oe, 1'b0);
            adr <= 1'b0;
         end
         role_a <= ~role_a;
         role_b <= ~role_b;
         repeat (20) @(posedge clk);
         chk(role_o, r[1:0]);
      end
      // Every rate code: half bit width and balance on the chain port
      for (c = 0; c < 4; c++) begin
         do_reset(1'b0, 1'b1, c[1:0]);
         spi_byte(8'h00);
         wait_oe(1'b1, 400);
         wait_oe(1'b0, 15000);
         chk(g2, 100000 / (2 * rates[c]));
         chk(h2, 8 * (100000 / (2 * rates[c])));
         chk((h2 - l2 <= 2 && l2 - h2 <= 2), 1'b1);
      end
      // Bridge fills while the slow chain drains, then refuses
      do_reset(1'b0, 1'b1, 2'h3);
      for (i = 0; i < 20; i++) begin
         spi_byte(i[7:0]);
         if (i == 1) chk(ovf, 1'b0);
      end
      repeat (4) @(posedge clk);
      chk(ovf, 1'b1);
      repeat (200) @(posedge clk);
      chk(ovf, 1'b1);
      end_sim();
   end
endmodule
